// ---- hdl/ptp_timestamp_clock.sv ----
// Precision-time system clock with addend accumulator and frame stamp decision
//
// Contract
// R1: Fine mode steps subsecond only on carry
// R2: Addend added to accumulator every tick
// R3: Addend writable any time, trims rate
// R4: Software derives addend and step values
// R5: Decimal mode wraps after 0x3BA9C9FF
// R6: Binary mode wraps after 0x7FFFFFFF
// R7: Coarse mode steps subsecond every tick
// R8: Version bit selects v2 or v1 parsing
// R9: Filter passes only matching destination addresses
// R10: Message-select field restricts stamped types
// R11: UDP over IPv4 gated by enable
// R12: UDP over IPv6 gated by enable
// R13: Raw Ethernet messages gated by enable
// R14: Every-frame option stamps all received frames
// R15: Every-frame without subset stamps default set
// R16: Step and configuration readable by software
// R17: Seconds count once per subsecond wrap
// R18: Seconds rollover sets readable clearable flag
// R19: Accumulator wraps modulo two to 32
// R20: Mode changes act next tick, seconds kept
`timescale 1ns/100ps

module ptp_timestamp_clock
  import ptp_clock_pkg::*;
(
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  // Register port
  input  wire logic [7:0]   addr_i,
  input  wire logic [31:0]  wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic      [31:0]  rdata_o,
  // Receive frame summary from the MAC
  input  wire rx_frame_type rx_frame_i,
  // Stamp result
  output logic              stamp_valid_o,
  output ptp_time_type      stamp_time_o,
  // Live time and status
  output ptp_time_type      time_o,
  output logic              sec_overflow_o
);

  // Configuration decode
  logic [CONFIG_BITS-1:0] config_reg;
  logic [31:0]            step_reg;
  logic [31:0]            addend_reg;
  logic [31:0]            acc_reg;
  logic [31:0]            subsec_reg;
  logic [31:0]            seconds_reg;
  logic                   overflow_reg;
  logic [31:0]            rdata_reg;
  logic                   stamp_valid_reg;
  ptp_time_type           stamp_time_reg;

  wire logic           fine_update_select;
  wire logic           decimal_wrap_select;
  wire logic           protocol_v2_select;
  wire logic           dest_address_filter_on;
  wire msg_select_type msg_select;
  wire logic           accept_udp_v4;
  wire logic           accept_udp_v6;
  wire logic           accept_raw_l2;
  wire logic           stamp_every_rx_frame;
  wire logic           clock_run;

  assign fine_update_select     = config_reg[FINE_BIT];
  assign decimal_wrap_select    = config_reg[DECIMAL_BIT];
  assign protocol_v2_select     = config_reg[V2_BIT];
  assign dest_address_filter_on = config_reg[FILTER_BIT];
  assign msg_select             = msg_select_type'(config_reg[SEL_LSB +: 4]);
  assign accept_udp_v4          = config_reg[UDP4_BIT];
  assign accept_udp_v6          = config_reg[UDP6_BIT];
  assign accept_raw_l2          = config_reg[RAW_BIT];
  assign stamp_every_rx_frame   = config_reg[EVERY_BIT];
  assign clock_run              = config_reg[RUN_BIT];

  // Register port decode
  wire logic hit_config;
  wire logic hit_step;
  wire logic hit_addend;
  wire logic hit_status;
  wire logic clear_overflow;
  wire logic wr_config;
  wire logic wr_step;
  wire logic wr_addend;

  assign hit_config     = addr_i == CONFIG_OFFSET;
  assign hit_step       = addr_i == STEP_OFFSET;
  assign hit_addend     = addr_i == ADDEND_OFFSET;
  assign hit_status     = addr_i == STATUS_OFFSET;
  assign clear_overflow = wr_i && hit_status && wdata_i[0];
  assign wr_config      = wr_i && hit_config;
  assign wr_step        = wr_i && hit_step;
  assign wr_addend      = wr_i && hit_addend;

  // Accumulator and subsecond arithmetic
  wire logic [32:0] acc_sum;
  wire logic        acc_carry;
  wire logic        step_now;
  wire logic [31:0] wrap_limit;
  wire logic [32:0] sub_sum;
  wire logic        sub_wrap;
  wire logic [31:0] subsec_next;
  wire logic [31:0] seconds_next;
  wire logic        sec_roll;
  wire logic [31:0] acc_next;

  assign acc_sum    = {1'b0, acc_reg} + {1'b0, addend_reg}; // R2 R3
  assign acc_carry  = acc_sum[32]; // R19
  assign acc_next   = clock_run ? acc_sum[31:0] : acc_reg; // R2 R19
  // Mode bits are read live, so a change acts on the very next tick
  assign step_now   = clock_run && (fine_update_select ? acc_carry : 1'b1); // R1 R7 R20
  assign wrap_limit = decimal_wrap_select ? DECIMAL_LIMIT : BINARY_LIMIT; // R5 R6
  assign sub_sum    = {1'b0, subsec_reg} + {1'b0, step_reg};
  assign sub_wrap   = sub_sum > {1'b0, wrap_limit}; // R5 R6
  // Counting restarts at zero past the limit; the excess carries over
  assign subsec_next = !step_now ? subsec_reg :
                       sub_wrap  ? 32'(sub_sum - {1'b0, wrap_limit} - 33'h0_0000_0001) :
                                   sub_sum[31:0];
  assign sec_roll     = step_now && sub_wrap && (seconds_reg == 32'hFFFF_FFFF); // R18
  assign seconds_next = (step_now && sub_wrap) ? seconds_reg + 32'h0000_0001 // R17
                                               : seconds_reg;

  // Frame stamp decision
  function automatic logic in_default_set(input logic [3:0] t);
    in_default_set = (t == MSG_SYNC) || (t == MSG_FOLLOW_UP) ||
                     (t == MSG_DELAY_REQ) || (t == MSG_DELAY_RESP);
  endfunction

  function automatic logic is_peer(input logic [3:0] t);
    is_peer = (t == MSG_PDELAY_REQ) || (t == MSG_PDELAY_RESP);
  endfunction

  logic type_selected;

  always_comb begin
    case (msg_select) // R10
      SEL_DEFAULT_SET:      type_selected = in_default_set(rx_frame_i.msg_type);
      SEL_SYNC_ONLY:        type_selected = rx_frame_i.msg_type == MSG_SYNC;
      SEL_DELAY_REQ_ONLY:   type_selected = rx_frame_i.msg_type == MSG_DELAY_REQ;
      SEL_ALL_MESSAGES:     type_selected = 1'b1;
      SEL_SYNC_PEER_DELAY:  type_selected = (rx_frame_i.msg_type == MSG_SYNC) ||
                                            is_peer(rx_frame_i.msg_type);
      SEL_DELAY_PEER_DELAY: type_selected = (rx_frame_i.msg_type == MSG_DELAY_REQ) ||
                                            is_peer(rx_frame_i.msg_type);
      SEL_SYNC_DELAY_SET:   type_selected = rx_frame_i.msg_type == MSG_DELAY_REQ;
      SEL_PEER_DELAY_ONLY:  type_selected = is_peer(rx_frame_i.msg_type);
      default:              type_selected = 1'b0;
    endcase
  end

  wire logic version_ok;
  wire logic udp_v4_ok;
  wire logic udp_v6_ok;
  wire logic raw_l2_ok;
  wire logic encap_ok;
  wire logic dest_ok;
  wire logic ptp_ok;
  wire logic stamp_now;

  assign version_ok = rx_frame_i.version == (protocol_v2_select ? 4'h2 : 4'h1); // R8
  assign udp_v4_ok  = rx_frame_i.encap == ENCAP_UDP_V4 && accept_udp_v4; // R11
  assign udp_v6_ok  = rx_frame_i.encap == ENCAP_UDP_V6 && accept_udp_v6; // R12
  assign raw_l2_ok  = rx_frame_i.encap == ENCAP_RAW_L2 && accept_raw_l2; // R13
  assign encap_ok   = udp_v4_ok || udp_v6_ok || raw_l2_ok;
  assign dest_ok    = !dest_address_filter_on || rx_frame_i.dest_match; // R9
  assign ptp_ok     = rx_frame_i.is_ptp && version_ok && encap_ok && dest_ok;
  // Stamps need a running clock; a stopped clock would give stale times
  assign stamp_now  = rx_frame_i.valid && clock_run &&
                      ((stamp_every_rx_frame && msg_select != SEL_DEFAULT_SET) || // R14
                       (ptp_ok && type_selected)); // R15

  // Read mux
  logic [31:0] read_value;

  always_comb begin
    case (addr_i) // R16
      CONFIG_OFFSET:  read_value = {{(32-CONFIG_BITS){1'b0}}, config_reg};
      STEP_OFFSET:    read_value = step_reg;
      ADDEND_OFFSET:  read_value = addend_reg;
      SUBSEC_OFFSET:  read_value = subsec_reg;
      SECONDS_OFFSET: read_value = seconds_reg;
      STATUS_OFFSET:  read_value = {31'h0000_0000, overflow_reg};
      default:        read_value = 32'h0000_0000;
    endcase
  end

  // Software-written registers, one block each
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      config_reg <= CONFIG_RESET;
    end else if (wr_config) begin
      config_reg <= wdata_i[CONFIG_BITS-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      step_reg <= STEP_RESET;
    end else if (wr_step) begin
      step_reg <= wdata_i;
    end
  end

  // Addend is never locked out, so software can trim the rate while running
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      addend_reg <= ADDEND_RESET;
    end else if (wr_addend) begin
      addend_reg <= wdata_i; // R3
    end
  end

  // Time counters
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      acc_reg <= 32'h0000_0000;
    end else begin
      acc_reg <= acc_next; // R2 R19
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      subsec_reg <= 32'h0000_0000;
    end else begin
      subsec_reg <= subsec_next;
    end
  end

  // Seconds only move on a subsecond wrap, never on a mode change
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      seconds_reg <= 32'h0000_0000;
    end else begin
      seconds_reg <= seconds_next; // R17 R20
    end
  end

  // Seconds overflow flag: a new rollover beats a clear in the same cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      overflow_reg <= 1'b0;
    end else if (sec_roll) begin
      overflow_reg <= 1'b1; // R18
    end else if (clear_overflow) begin
      overflow_reg <= 1'b0;
    end
  end

  // Read data, stamp pulse and stamp time
  wire logic [31:0] rdata_next;
  wire ptp_time_type time_now;
  wire ptp_time_type stamp_time_next;

  assign rdata_next      = rd_i ? read_value : 32'h0000_0000;
  assign time_now        = '{seconds: seconds_reg, subsec: subsec_reg};
  assign stamp_time_next = stamp_now ? time_now : stamp_time_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stamp_valid_reg <= 1'b0;
    end else begin
      stamp_valid_reg <= stamp_now;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stamp_time_reg <= '0;
    end else begin
      stamp_time_reg <= stamp_time_next;
    end
  end

  assign rdata_o        = rdata_reg;
  assign stamp_valid_o  = stamp_valid_reg;
  assign stamp_time_o   = stamp_time_reg;
  assign time_o         = time_now;
  assign sec_overflow_o = overflow_reg;

endmodule

// ---- hdl/ptp_clock_pkg.sv ----
// Constants, register map and carrier types of the precision-time clock
package ptp_clock_pkg;

  // Register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] CONFIG_OFFSET   = 8'h00;
  localparam logic [7:0] STEP_OFFSET     = 8'h04;
  localparam logic [7:0] ADDEND_OFFSET   = 8'h08;
  localparam logic [7:0] SUBSEC_OFFSET   = 8'h0C;
  localparam logic [7:0] SECONDS_OFFSET  = 8'h10;
  localparam logic [7:0] STATUS_OFFSET   = 8'h14;

  // Configuration field positions
  localparam int FINE_BIT    = 0;
  localparam int DECIMAL_BIT = 1;
  localparam int V2_BIT      = 2;
  localparam int FILTER_BIT  = 3;
  localparam int SEL_LSB     = 4;
  localparam int UDP4_BIT    = 8;
  localparam int UDP6_BIT    = 9;
  localparam int RAW_BIT     = 10;
  localparam int EVERY_BIT   = 11;
  localparam int RUN_BIT     = 12;
  localparam int CONFIG_BITS = 13;

  // Reset values
  localparam logic [CONFIG_BITS-1:0] CONFIG_RESET = 13'h1700;
  localparam logic [31:0]            STEP_RESET   = 32'h0000_0014;
  localparam logic [31:0]            ADDEND_RESET = 32'h0000_0000;

  // Subsecond wrap points
  localparam logic [31:0] DECIMAL_LIMIT = 32'h3BA9_C9FF;
  localparam logic [31:0] BINARY_LIMIT  = 32'h7FFF_FFFF;

  // Message-subset selection codes
  typedef enum logic [3:0] {
    SEL_DEFAULT_SET       = 4'h0,
    SEL_SYNC_ONLY         = 4'h1,
    SEL_DELAY_REQ_ONLY    = 4'h2,
    SEL_ALL_MESSAGES      = 4'h3,
    SEL_SYNC_PEER_DELAY   = 4'h4,
    SEL_DELAY_PEER_DELAY  = 4'h5,
    SEL_SYNC_DELAY_SET    = 4'h6,
    SEL_PEER_DELAY_ONLY   = 4'h7
  } msg_select_type;

  // Message type codes delivered by the frame parser
  localparam logic [3:0] MSG_SYNC        = 4'h0;
  localparam logic [3:0] MSG_DELAY_REQ   = 4'h1;
  localparam logic [3:0] MSG_PDELAY_REQ  = 4'h2;
  localparam logic [3:0] MSG_PDELAY_RESP = 4'h3;
  localparam logic [3:0] MSG_FOLLOW_UP   = 4'h8;
  localparam logic [3:0] MSG_DELAY_RESP  = 4'h9;

  // Encapsulation codes
  typedef enum logic [1:0] {
    ENCAP_OTHER  = 2'h0,
    ENCAP_UDP_V4 = 2'h1,
    ENCAP_UDP_V6 = 2'h2,
    ENCAP_RAW_L2 = 2'h3
  } encap_type;

  // One received frame, as summarised by the MAC receive path
  typedef struct packed {
    logic       valid;
    logic       is_ptp;
    encap_type  encap;
    logic [3:0] version;
    logic [3:0] msg_type;
    logic       dest_match;
  } rx_frame_type;

  // A time value
  typedef struct packed {
    logic [31:0] seconds;
    logic [31:0] subsec;
  } ptp_time_type;

endpackage

// ---- verif/ptp_clock_sva.sv ----
// Port checker for the precision-time clock, bound into the design
`timescale 1ns/100ps
module ptp_clock_sva
  import ptp_clock_pkg::*;
(
  // Clock, reset and register port
  input wire logic         clock_i,
  input wire logic         rst_i,
  input wire logic [7:0]   addr_i,
  input wire logic [31:0]  wdata_i,
  input wire logic         wr_i,
  input wire logic         rd_i,
  input wire logic [31:0]  rdata_o,
  // Frames and time
  input wire rx_frame_type rx_frame_i,
  input wire logic         stamp_valid_o,
  input wire ptp_time_type stamp_time_o,
  input wire ptp_time_type time_o,
  input wire logic         sec_overflow_o
);
  logic [12:0] cfg_reg;
  logic [31:0] step_reg;
  logic [31:0] add_reg;
  logic [31:0] acc_reg;
  // Shadow datapath: predicts every tick exactly from the register writes
  wire [32:0] acc_sum = acc_reg + add_reg;
  // Reset gates the tick: the disable condition reads live values, not sampled ones
  wire        tick    = ~rst_i & cfg_reg[RUN_BIT] & (~cfg_reg[FINE_BIT] | acc_sum[32]);
  wire [31:0] lim     = cfg_reg[DECIMAL_BIT] ? DECIMAL_LIMIT : BINARY_LIMIT;
  wire [32:0] sum     = time_o.subsec + step_reg;
  wire [32:0] over    = sum - lim - 33'h1;
  wire        wrap    = tick & (sum > lim);
  wire [31:0] sub_nxt = wrap ? over[31:0] : tick ? sum[31:0] : time_o.subsec;
  wire [3:0]  enc_vec = {cfg_reg[RAW_BIT], cfg_reg[UDP6_BIT], cfg_reg[UDP4_BIT], 1'b0};
  wire        any_on  = cfg_reg[EVERY_BIT] & (|cfg_reg[7:4]) & cfg_reg[RUN_BIT];
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cfg_reg  <= CONFIG_RESET;
      step_reg <= STEP_RESET;
      add_reg  <= ADDEND_RESET;
      acc_reg  <= 32'h0;
    end else begin
      acc_reg  <= cfg_reg[RUN_BIT] ? acc_sum[31:0] : acc_reg;
      cfg_reg  <= (wr_i && addr_i == CONFIG_OFFSET) ? wdata_i[12:0] : cfg_reg;
      step_reg <= (wr_i && addr_i == STEP_OFFSET) ? wdata_i : step_reg;
      add_reg  <= (wr_i && addr_i == ADDEND_OFFSET) ? wdata_i : add_reg;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence frame_in;
    rx_frame_i.valid && !any_on;
  endsequence
  a_coarse_sub: assert property (!cfg_reg[FINE_BIT] |=> time_o.subsec == $past(sub_nxt))
    else $error("coarse subsec step wrong");
  a_fine_sub: assert property (cfg_reg[FINE_BIT] |=> time_o.subsec == $past(sub_nxt))
    else $error("fine subsec step wrong");
  a_sec_count: assert property (1'b1 |=> time_o.seconds == $past(time_o.seconds) + 32'($past(wrap)))
    else $error("seconds count wrong");
  a_stamp_time: assert property (stamp_valid_o |-> $past(rx_frame_i.valid) && stamp_time_o == $past(time_o))
    else $error("stamp time wrong");
  a_every_stamp: assert property (rx_frame_i.valid && any_on |=> stamp_valid_o)
    else $error("every-frame stamp missing");
  a_encap_drop: assert property (frame_in ##0 !enc_vec[rx_frame_i.encap] |=> !stamp_valid_o)
    else $error("disabled encapsulation stamped");
  a_filter_drop: assert property (frame_in ##0 cfg_reg[FILTER_BIT] && !rx_frame_i.dest_match |=> !stamp_valid_o)
    else $error("filtered frame stamped");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data outside read slot");
  a_overflow_rise: assert property ($rose(sec_overflow_o) |->
      $past(time_o.seconds) == 32'hFFFF_FFFF && time_o.seconds == 32'h0)
    else $error("overflow flag without seconds rollover");
  a_overflow_clear: assert property (wr_i && addr_i == STATUS_OFFSET && wdata_i[0] &&
      !(wrap && time_o.seconds == 32'hFFFF_FFFF) |=> !sec_overflow_o)
    else $error("overflow flag not cleared");
endmodule
bind ptp_timestamp_clock ptp_clock_sva chk_u (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .rx_frame_i, .stamp_valid_o, .stamp_time_o, .time_o, .sec_overflow_o);

// ---- verif/rx_frame_model.sv ----
// Receive-path model handing frame summaries to the clock
`timescale 1ns/100ps
module rx_frame_model
  import ptp_clock_pkg::*;
(
  // Clock and frame summary
  input  wire logic    clock_i,
  output rx_frame_type frame_o
);
  initial frame_o = '0;
  // Fields invert once a frame is done, so stale values cannot match
  task automatic send(input rx_frame_type f);
    @(posedge clock_i);
    frame_o <= f;
    @(posedge clock_i);
    frame_o <= {1'b0, ~f[11:0]};
  endtask
endmodule

// ---- verif/ptp_timestamp_clock_tb.sv ----
// Self-checking bench for the precision-time clock
`timescale 1ns/100ps
module ptp_timestamp_clock_tb
  import ptp_clock_pkg::*;
;
  logic         clock_i, rst_i, wr_i, rd_i, stamp_valid_o, sec_overflow_o;
  logic [7:0]   addr_i;
  logic [31:0]  wdata_i, rdata_o, sub, sec, acc, stp, add;
  ptp_time_type stamp_time_o, time_o;
  rx_frame_type rx_frame_i;
  int           errors, tests_run;
  logic [3:0]   mts [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
  ptp_timestamp_clock dut_u (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .rx_frame_i, .stamp_valid_o, .stamp_time_o, .time_o, .sec_overflow_o);
  rx_frame_model src_u (.clock_i, .frame_o(rx_frame_i));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i    <= 1'b0;
    if (a == STEP_OFFSET) stp = d;
    if (a == ADDEND_OFFSET) add = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1;
    check("rdata", e, rdata_o);
  endtask
  // Runs n+2 ticks, then freezes the clock so the local model can be compared
  task automatic go(input logic [12:0] c, input int n);
    logic [32:0] s;
    logic [31:0] lim;
    lim = c[DECIMAL_BIT] ? DECIMAL_LIMIT : BINARY_LIMIT;
    wr(CONFIG_OFFSET, {19'h0, c | 13'h1000});
    repeat (n) @(posedge clock_i);
    wr(CONFIG_OFFSET, {19'h0, c});
    for (int i = 0; i < n + 2; i++) begin
      s = acc + add;
      acc = s[31:0];
      if (!c[FINE_BIT] || s[32]) begin
        s = sub + stp;
        sec = sec + 32'(s > lim);
        s = s > lim ? s - lim - 33'h1 : s;
        sub = s[31:0];
      end
    end
    rd(SUBSEC_OFFSET, sub);
    rd(SECONDS_OFFSET, sec);
    check("time_sub", sub, time_o.subsec);
    check("time_sec", sec, time_o.seconds);
  endtask
  task automatic frame(input encap_type en, input logic [3:0] v, input logic [3:0] m,
                       input logic e, input logic d = 1'b1, input logic p = 1'b1);
    src_u.send('{1'b1, p, en, v, m, d});
    #1;
    check("stamp", {31'h0, e}, {31'h0, stamp_valid_o});
  endtask
  function automatic logic hit(input int s, input logic [3:0] m);
    case (s)
      0: return m inside {MSG_SYNC, MSG_FOLLOW_UP, MSG_DELAY_REQ, MSG_DELAY_RESP};
      1: return m == MSG_SYNC;
      2, 6: return m == MSG_DELAY_REQ;
      3: return 1'b1;
      4: return m inside {MSG_SYNC, MSG_PDELAY_REQ, MSG_PDELAY_RESP};
      5: return m inside {MSG_DELAY_REQ, MSG_PDELAY_REQ, MSG_PDELAY_RESP};
      default: return m inside {MSG_PDELAY_REQ, MSG_PDELAY_RESP};
    endcase
  endfunction
  initial begin
    {rst_i, wr_i, rd_i, addr_i, wdata_i} = {1'b1, 42'h0};
    {errors, tests_run, sec, acc, add} = '0;
    sub = 32'h78;
    stp = 32'h14;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(CONFIG_OFFSET, 32'h1700);
    rd(STEP_OFFSET, 32'h14);
    wr(CONFIG_OFFSET, 32'h0700);
    rd(SUBSEC_OFFSET, sub);
    rd(8'h3C, 32'h0);
    rd(STATUS_OFFSET, 32'h0);
    check("overflow", 32'h0, {31'h0, sec_overflow_o});
    wr(STATUS_OFFSET, 32'h1);
    rd(STATUS_OFFSET, 32'h0);
    wr(STEP_OFFSET, 32'h4000_0000);
    go(13'h0000, 2);
    go(13'h0002, 3);
    wr(ADDEND_OFFSET, 32'h8000_0000);
    rd(ADDEND_OFFSET, 32'h8000_0000);
    go(13'h0001, 4);
    wr(ADDEND_OFFSET, 32'h8000_0001);
    go(13'h0003, 5);
    for (int s = 0; s < 8; s++) begin
      wr(CONFIG_OFFSET, 32'h1700 | 32'(s << 4));
      foreach (mts[j]) frame(ENCAP_UDP_V4, 4'h1, mts[j], hit(s, mts[j]));
    end
    wr(CONFIG_OFFSET, 32'h1780);
    frame(ENCAP_UDP_V4, 4'h1, MSG_SYNC, 1'b0);
    wr(CONFIG_OFFSET, 32'h1734);
    frame(ENCAP_UDP_V6, 4'h2, MSG_SYNC, 1'b1);
    frame(ENCAP_RAW_L2, 4'h1, MSG_SYNC, 1'b0);
    frame(ENCAP_OTHER, 4'h2, MSG_SYNC, 1'b0);
    frame(ENCAP_RAW_L2, 4'h2, MSG_SYNC, 1'b0, 1'b1, 1'b0);
    wr(CONFIG_OFFSET, 32'h1638);
    frame(ENCAP_UDP_V4, 4'h1, MSG_SYNC, 1'b0);
    frame(ENCAP_RAW_L2, 4'h1, MSG_SYNC, 1'b1);
    frame(ENCAP_RAW_L2, 4'h1, MSG_SYNC, 1'b0, 1'b0);
    wr(CONFIG_OFFSET, 32'h1830);
    frame(ENCAP_OTHER, 4'h7, 4'h5, 1'b1, 1'b0, 1'b0);
    wr(CONFIG_OFFSET, 32'hFFFF_F900);
    frame(ENCAP_UDP_V4, 4'h1, MSG_FOLLOW_UP, 1'b1);
    frame(ENCAP_UDP_V4, 4'h1, MSG_PDELAY_REQ, 1'b0);
    rd(CONFIG_OFFSET, 32'h1900);
    print_verdict();
  end
endmodule
